// ===== core/interrupt_priority_config_bank.sv
// Interrupt priority configuration bank: five priority registers on Avalon-MM,
// with per-source decoded enable and level for the arbitration logic.
// Assumes a single 200 MHz clock, synchronous inputs and one bus master.
`timescale 1ns/10ps
`include "prio_regs.svh"

module interrupt_priority_config_bank (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [`ADDR_WIDTH-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  output prio_pkg::level_s [`DEBUG_SOURCES-1:0] DEBUG_LEVELS,
  output prio_pkg::level_s [`PERIPH_SOURCES-1:0] PERIPH_LEVELS
);

  // --------------------------------------------------------------------------
  // Bus slave state
  // --------------------------------------------------------------------------
  prio_pkg::bus_state_e state;
  prio_pkg::bus_state_e next_state;
  logic next_waitrequest;
  logic [2:0] req_idx;
  logic store_wr;
  logic store_rd;
  logic [15:0] lanes;
  prio_pkg::bank_t rd_word;
  prio_pkg::bank_array_t banks;
  prio_pkg::bank_array_t next_banks;

  // Index of the current request, unmapped addresses give IDX_NONE
  assign req_idx = prio_pkg::index_of(ADDRESS);

  // Byte enables to a bit strobe; lanes 2 and 3 carry no register bits
  assign lanes = {{8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};

  // Every access costs one wait cycle: the read word is registered in the store,
  // which keeps the read path short at 200 MHz at the cost of one cycle per access
  always_comb begin
    next_state = state;
    store_wr = 1'b0;
    store_rd = 1'b0;
    case (state)
      prio_pkg::BUS_IDLE: begin
        if (READ || WRITE) begin
          next_state = prio_pkg::BUS_ACK;
          store_rd = READ;
        end
      end
      prio_pkg::BUS_ACK: begin
        // The master samples waitrequest low at this edge; the write lands here
        next_state = prio_pkg::BUS_IDLE;
        store_wr = WRITE;
      end
      default: begin
        next_state = prio_pkg::BUS_IDLE;
      end
    endcase
    next_waitrequest = (next_state != prio_pkg::BUS_ACK);
  end

  // Bus state registers
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state <= prio_pkg::BUS_IDLE;
      WAITREQUEST <= 1'b1;
    end else if (CE) begin
      state <= next_state;
      WAITREQUEST <= next_waitrequest;
    end
  end

  // --------------------------------------------------------------------------
  // Register store
  // --------------------------------------------------------------------------
  // Holds the five banks, applies byte lanes and reserved masks
  prio_bank_store store (
    .clock(CLOCK),
    .rst_n(RST_N),
    .ce(CE),
    .wr_en(store_wr),
    .wr_idx(req_idx),
    .wr_data(WRITEDATA[15:0]),
    .wr_lanes(lanes),
    .rd_en(store_rd),
    .rd_idx(req_idx),
    .rd_data(rd_word),
    .banks(banks),
    .next_banks(next_banks)
  );

  // Registers are 16 bits wide; the upper half of the data word reads zero
  assign READDATA = {`READ_PAD, rd_word};

  // --------------------------------------------------------------------------
  // Field extraction
  // --------------------------------------------------------------------------
  prio_pkg::bank_t b_one;
  prio_pkg::bank_t b_two;
  prio_pkg::bank_t b_three;
  prio_pkg::bank_t b_four;
  prio_pkg::bank_t b_five;

  // Decoding works from the next bank values so that decoded outputs and the
  // stored fields change at the same edge, never a cycle apart
  assign b_one = next_banks[`IDX_BANK_ONE - 3'h1];
  assign b_two = next_banks[`IDX_BANK_TWO - 3'h1];
  assign b_three = next_banks[`IDX_BANK_THREE - 3'h1];
  assign b_four = next_banks[`IDX_BANK_FOUR - 3'h1];
  assign b_five = next_banks[`IDX_BANK_FIVE - 3'h1];

  // --------------------------------------------------------------------------
  // Bank one fields
  // --------------------------------------------------------------------------
  // Raw codes of the debug sources
  logic [1:0] debug_rx_full_level;
  logic [1:0] debug_tx_empty_level;
  logic [1:0] trace_buffer_level;

  // Bits 15-6 are reserved and feed no decoder
  assign debug_rx_full_level = b_one[`POS_DEBUG_RX_FULL +: 2];
  assign debug_tx_empty_level = b_one[`POS_DEBUG_TX_EMPTY +: 2];
  assign trace_buffer_level = b_one[`POS_TRACE_BUFFER +: 2];

  // --------------------------------------------------------------------------
  // Bank two fields
  // --------------------------------------------------------------------------
  // Raw codes of flash, PLL, brownout and external lines
  logic [1:0] flash_buffers_empty_level;
  logic [1:0] flash_cmd_done_level;
  logic [1:0] flash_fault_level;
  logic [1:0] pll_sync_loss_level;
  logic [1:0] brownout_level;
  logic [1:0] ext_line_b_level;
  logic [1:0] ext_line_a_level;

  // Bits 5-4 are reserved: the store masks them on write,
  // so a decoder there would only ever see 00
  assign flash_buffers_empty_level = b_two[`POS_FLASH_BUFFERS_EMPTY +: 2];
  assign flash_cmd_done_level = b_two[`POS_FLASH_CMD_DONE +: 2];
  assign flash_fault_level = b_two[`POS_FLASH_FAULT +: 2];
  assign pll_sync_loss_level = b_two[`POS_PLL_SYNC_LOSS +: 2];
  assign brownout_level = b_two[`POS_BROWNOUT +: 2];
  assign ext_line_b_level = b_two[`POS_EXT_LINE_B +: 2];
  assign ext_line_a_level = b_two[`POS_EXT_LINE_A +: 2];

  // --------------------------------------------------------------------------
  // Bank three fields
  // --------------------------------------------------------------------------
  // Raw codes of ports D to F and the CAN sources
  logic [1:0] port_d_level;
  logic [1:0] port_e_level;
  logic [1:0] port_f_level;
  logic [1:0] can_message_buffer_level;
  logic [1:0] can_wake_level;
  logic [1:0] can_fault_level;
  logic [1:0] can_busoff_level;

  // Bits 1-0 are reserved; bus-off is the lowest field and
  // the CAN group runs downward from the message buffer
  assign port_d_level = b_three[`POS_PORT_D +: 2];
  assign port_e_level = b_three[`POS_PORT_E +: 2];
  assign port_f_level = b_three[`POS_PORT_F +: 2];
  assign can_message_buffer_level = b_three[`POS_CAN_MESSAGE_BUFFER +: 2];
  assign can_wake_level = b_three[`POS_CAN_WAKE +: 2];
  assign can_fault_level = b_three[`POS_CAN_FAULT +: 2];
  assign can_busoff_level = b_three[`POS_CAN_BUSOFF +: 2];

  // --------------------------------------------------------------------------
  // Bank four fields
  // --------------------------------------------------------------------------
  // Raw codes of the SPI sources and ports A to C
  logic [1:0] spi_zero_rx_full_level;
  logic [1:0] spi_one_tx_empty_level;
  logic [1:0] spi_one_rx_full_level;
  logic [1:0] port_a_level;
  logic [1:0] port_b_level;
  logic [1:0] port_c_level;

  // Bits 9-6 are reserved; ports A to C sit in the low byte,
  // so software can set all three with one byte-lane write
  assign spi_zero_rx_full_level = b_four[`POS_SPI_ZERO_RX_FULL +: 2];
  assign spi_one_tx_empty_level = b_four[`POS_SPI_ONE_TX_EMPTY +: 2];
  assign spi_one_rx_full_level = b_four[`POS_SPI_ONE_RX_FULL +: 2];
  assign port_a_level = b_four[`POS_PORT_A +: 2];
  assign port_b_level = b_four[`POS_PORT_B +: 2];
  assign port_c_level = b_four[`POS_PORT_C +: 2];

  // --------------------------------------------------------------------------
  // Bank five fields
  // --------------------------------------------------------------------------
  // Raw codes of quadrature, serial and SPI0 transmit sources
  logic [1:0] quad_one_index_level;
  logic [1:0] quad_one_home_level;
  logic [1:0] serial_one_rx_full_level;
  logic [1:0] serial_one_rx_fault_level;
  logic [1:0] serial_one_tx_idle_level;
  logic [1:0] serial_one_tx_empty_level;
  logic [1:0] spi_zero_tx_empty_level;

  // Bits 7-6 read zero; the serial fields straddle them,
  // receive fields above and transmit fields below
  assign quad_one_index_level = b_five[`POS_QUAD_ONE_INDEX +: 2];
  assign quad_one_home_level = b_five[`POS_QUAD_ONE_HOME +: 2];
  assign serial_one_rx_full_level = b_five[`POS_SERIAL_ONE_RX_FULL +: 2];
  assign serial_one_rx_fault_level = b_five[`POS_SERIAL_ONE_RX_FAULT +: 2];
  assign serial_one_tx_idle_level = b_five[`POS_SERIAL_ONE_TX_IDLE +: 2];
  assign serial_one_tx_empty_level = b_five[`POS_SERIAL_ONE_TX_EMPTY +: 2];
  assign spi_zero_tx_empty_level = b_five[`POS_SPI_ZERO_TX_EMPTY +: 2];

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  // Decoded enable and level per source, ahead of the output registers
  prio_pkg::level_s [`DEBUG_SOURCES-1:0] next_debug;
  prio_pkg::level_s [`PERIPH_SOURCES-1:0] next_periph;

  // Debug sources use the shifted-up level range 1 to 3;
  // peripherals top out at level 2, so only a debug source
  // can ever ask for level 3
  always_comb begin
    next_debug[0] = prio_pkg::decode_debug(debug_rx_full_level);
    next_debug[1] = prio_pkg::decode_debug(debug_tx_empty_level);
    next_debug[2] = prio_pkg::decode_debug(trace_buffer_level);
  end

  // Peripheral sources, bank two to bank five in descending bit order;
  // output order follows field order, so a software table can walk
  // the banks and the outputs side by side
  always_comb begin
    // Bank two: flash, PLL, brownout, external lines
    next_periph[0] = prio_pkg::decode_periph(flash_buffers_empty_level);
    next_periph[1] = prio_pkg::decode_periph(flash_cmd_done_level);
    next_periph[2] = prio_pkg::decode_periph(flash_fault_level);
    next_periph[3] = prio_pkg::decode_periph(pll_sync_loss_level);
    next_periph[4] = prio_pkg::decode_periph(brownout_level);
    next_periph[5] = prio_pkg::decode_periph(ext_line_b_level);
    next_periph[6] = prio_pkg::decode_periph(ext_line_a_level);

    // Bank three: ports D to F and the CAN sources
    next_periph[7] = prio_pkg::decode_periph(port_d_level);
    next_periph[8] = prio_pkg::decode_periph(port_e_level);
    next_periph[9] = prio_pkg::decode_periph(port_f_level);
    next_periph[10] = prio_pkg::decode_periph(can_message_buffer_level);
    next_periph[11] = prio_pkg::decode_periph(can_wake_level);
    next_periph[12] = prio_pkg::decode_periph(can_fault_level);
    next_periph[13] = prio_pkg::decode_periph(can_busoff_level);

    // Bank four: SPI sources and ports A to C
    next_periph[14] = prio_pkg::decode_periph(spi_zero_rx_full_level);
    next_periph[15] = prio_pkg::decode_periph(spi_one_tx_empty_level);
    next_periph[16] = prio_pkg::decode_periph(spi_one_rx_full_level);
    next_periph[17] = prio_pkg::decode_periph(port_a_level);
    next_periph[18] = prio_pkg::decode_periph(port_b_level);
    next_periph[19] = prio_pkg::decode_periph(port_c_level);

    // Bank five: quadrature, serial and SPI0 transmit sources
    next_periph[20] = prio_pkg::decode_periph(quad_one_index_level);
    next_periph[21] = prio_pkg::decode_periph(quad_one_home_level);
    next_periph[22] = prio_pkg::decode_periph(serial_one_rx_full_level);
    next_periph[23] = prio_pkg::decode_periph(serial_one_rx_fault_level);
    next_periph[24] = prio_pkg::decode_periph(serial_one_tx_idle_level);
    next_periph[25] = prio_pkg::decode_periph(serial_one_tx_empty_level);
    next_periph[26] = prio_pkg::decode_periph(spi_zero_tx_empty_level);
  end

  // --------------------------------------------------------------------------
  // Decoded output registers
  // --------------------------------------------------------------------------
  // The enabled bits double as the wake mask: the power controller must latch
  // them before clocks stop, since nothing here runs while the clock is off
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      DEBUG_LEVELS <= '0;
      PERIPH_LEVELS <= '0;
    end else if (CE) begin
      DEBUG_LEVELS <= next_debug;
      PERIPH_LEVELS <= next_periph;
    end
  end

endmodule : interrupt_priority_config_bank

// ===== core/prio_regs.svh
// Constants for the interrupt priority configuration bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PRIO_REGS_SVH
`define PRIO_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_BANK_ONE 3'h1
`define IDX_BANK_TWO 3'h2
`define IDX_BANK_THREE 3'h3
`define IDX_BANK_FOUR 3'h4
`define IDX_BANK_FIVE 3'h5
`define IDX_NONE 3'h0
`define BANK_COUNT 5
`define ADDR_WIDTH 8

// ----------------------------------------------------------------------------
// Reset values and writable masks (reserved bits are zero in the mask)
// ----------------------------------------------------------------------------
`define BANK_RESET 16'h0000
`define MASK_BANK_ONE 16'h003F
`define MASK_BANK_TWO 16'hFFCF
`define MASK_BANK_THREE 16'hFFFC
`define MASK_BANK_FOUR 16'hFC3F
`define MASK_BANK_FIVE 16'hFF3F
`define READ_UNMAPPED 16'h0000
`define READ_PAD 16'h0000
`define CODE_DISABLED 2'h0

// ----------------------------------------------------------------------------
// Field positions (low bit of each 2-bit field)
// ----------------------------------------------------------------------------
`define POS_DEBUG_RX_FULL 4
`define POS_DEBUG_TX_EMPTY 2
`define POS_TRACE_BUFFER 0
`define POS_FLASH_BUFFERS_EMPTY 14
`define POS_FLASH_CMD_DONE 12
`define POS_FLASH_FAULT 10
`define POS_PLL_SYNC_LOSS 8
`define POS_BROWNOUT 6
`define POS_EXT_LINE_B 2
`define POS_EXT_LINE_A 0
`define POS_PORT_D 14
`define POS_PORT_E 12
`define POS_PORT_F 10
`define POS_CAN_MESSAGE_BUFFER 8
`define POS_CAN_WAKE 6
`define POS_CAN_FAULT 4
`define POS_CAN_BUSOFF 2
`define POS_SPI_ZERO_RX_FULL 14
`define POS_SPI_ONE_TX_EMPTY 12
`define POS_SPI_ONE_RX_FULL 10
`define POS_PORT_A 4
`define POS_PORT_B 2
`define POS_PORT_C 0
`define POS_QUAD_ONE_INDEX 14
`define POS_QUAD_ONE_HOME 12
`define POS_SERIAL_ONE_RX_FULL 10
`define POS_SERIAL_ONE_RX_FAULT 8
`define POS_SERIAL_ONE_TX_IDLE 4
`define POS_SERIAL_ONE_TX_EMPTY 2
`define POS_SPI_ZERO_TX_EMPTY 0
`define DEBUG_SOURCES 3
`define PERIPH_SOURCES 27

`endif

// ===== core/prio_pkg.sv
// Types and shared decode functions for the priority configuration bank.
// Assumes prio_regs.svh is on the include path.
`include "prio_regs.svh"

package prio_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef logic [15:0] bank_t;
  typedef bank_t [`BANK_COUNT-1:0] bank_array_t;

  typedef struct packed {
    logic enabled;
    logic [1:0] level;
  } level_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_e;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Debug sources: code equals level, 00 means disabled
  function automatic level_s decode_debug(input logic [1:0] code);
    level_s r;
    r.enabled = (code != `CODE_DISABLED);
    r.level = code;
    return r;
  endfunction : decode_debug

  // Peripheral sources: level is one below the code, so level 3 is unreachable
  function automatic level_s decode_periph(input logic [1:0] code);
    level_s r;
    r.enabled = (code != `CODE_DISABLED);
    r.level = (code == `CODE_DISABLED) ? 2'h0 : 2'(code - 2'h1);
    return r;
  endfunction : decode_periph

  // Byte address to register index, IDX_NONE when unmapped or misaligned
  function automatic logic [2:0] index_of(input logic [`ADDR_WIDTH-1:0] addr);
    logic [2:0] r;
    r = `IDX_NONE;
    if ((addr[1:0] == 2'h0) && (addr[7:5] == 3'h0) && (addr[4:2] >= `IDX_BANK_ONE) &&
        (addr[4:2] <= `IDX_BANK_FIVE)) begin
      r = addr[4:2];
    end
    return r;
  endfunction : index_of

  // Writable bits of each register
  function automatic bank_t mask_of(input logic [2:0] idx);
    bank_t r;
    case (idx)
      `IDX_BANK_ONE: r = `MASK_BANK_ONE;
      `IDX_BANK_TWO: r = `MASK_BANK_TWO;
      `IDX_BANK_THREE: r = `MASK_BANK_THREE;
      `IDX_BANK_FOUR: r = `MASK_BANK_FOUR;
      `IDX_BANK_FIVE: r = `MASK_BANK_FIVE;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction : mask_of

endpackage : prio_pkg

// ===== core/prio_bank_store.sv
// Five-word store of priority registers with masked writes and registered reads.
// Assumes the caller presents at most one write and one read per cycle.
`timescale 1ns/10ps
`include "prio_regs.svh"

module prio_bank_store (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] wr_lanes,
  input wire logic rd_en,
  input wire logic [2:0] rd_idx,
  output prio_pkg::bank_t rd_data,
  output prio_pkg::bank_array_t banks,
  output prio_pkg::bank_array_t next_banks
);

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  prio_pkg::bank_t next_rd_data;
  prio_pkg::bank_t keep;

  // Reserved bits never take write data, so they stay at reset zero
  always_comb begin
    keep = wr_lanes & prio_pkg::mask_of(wr_idx);
    next_banks = banks;
    next_rd_data = rd_data;
    if (wr_en && (wr_idx != `IDX_NONE)) begin
      next_banks[wr_idx - 3'h1] = (banks[wr_idx - 3'h1] & ~keep) | (wr_data & keep);
    end
    if (rd_en) begin
      next_rd_data = (rd_idx == `IDX_NONE) ? `READ_UNMAPPED : banks[rd_idx - 3'h1];
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Every field comes out of reset as 00, disabled
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      banks <= {`BANK_COUNT{`BANK_RESET}};
      rd_data <= `READ_UNMAPPED;
    end else if (ce) begin
      banks <= next_banks;
      rd_data <= next_rd_data;
    end
  end

endmodule : prio_bank_store

// ===== testbench/prio_bank_props.sv
// Checker for the priority bank: bus handshake, decode and reserved bits.
// Assumes it is bound to the bank top and sees only its ports.
`timescale 1ns/10ps
`include "prio_regs.svh"
module prio_bank_props (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [`ADDR_WIDTH-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  input prio_pkg::level_s [`DEBUG_SOURCES-1:0] DEBUG_LEVELS,
  input prio_pkg::level_s [`PERIPH_SOURCES-1:0] PERIPH_LEVELS
);
  logic [15:0] resv;
  logic dec_ok;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Reserved bits per word; an unmapped word reads all zero
  always_comb begin
    case (ADDRESS)
      8'h04: resv = 16'hFFC0;
      8'h08: resv = 16'h0030;
      8'h0C: resv = 16'h0003;
      8'h10: resv = 16'h03C0;
      8'h14: resv = 16'h00C0;
      default: resv = 16'hFFFF;
    endcase
  end
  // Enable must agree with the code; peripherals never report level 3
  always_comb begin
    dec_ok = 1'b1;
    for (int i = 0; i < `DEBUG_SOURCES; i++) begin
      if (DEBUG_LEVELS[i].enabled != (DEBUG_LEVELS[i].level != 2'h0)) dec_ok = 1'b0;
    end
    for (int i = 0; i < `PERIPH_SOURCES; i++) begin
      if (PERIPH_LEVELS[i].level == 2'h3) dec_ok = 1'b0;
      if (!PERIPH_LEVELS[i].enabled && PERIPH_LEVELS[i].level != 2'h0) dec_ok = 1'b0;
    end
  end
  a_wait_one: assert property (CE && WAITREQUEST && (READ || WRITE) |=> !WAITREQUEST)
    else $error("access not answered in one cycle");
  a_wait_single: assert property (CE && !WAITREQUEST |=> WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  a_reset_clear: assert property ($rose(RST_N) |-> WAITREQUEST && READDATA == 32'h0 &&
    DEBUG_LEVELS == '0 && PERIPH_LEVELS == '0) else $error("state not cleared by reset");
  a_reserved_zero: assert property (READ && !WAITREQUEST |->
    (READDATA[15:0] & resv) == 16'h0 && READDATA[31:16] == 16'h0) else $error("reserved bit read nonzero");
  a_decode_code: assert property (dec_ok)
    else $error("level decode out of range");
  a_debug_land: assert property (WRITE && !WAITREQUEST && CE && ADDRESS == 8'h04 && BYTEENABLE[0] |=>
    DEBUG_LEVELS[0] == {$past(WRITEDATA[5:4]) != 2'h0, $past(WRITEDATA[5:4])}) else $error("debug field wrong");
  a_periph_land: assert property (WRITE && !WAITREQUEST && CE && ADDRESS == 8'h08 && BYTEENABLE[1] &&
    WRITEDATA[15:14] != 2'h0 |=> PERIPH_LEVELS[0].enabled && PERIPH_LEVELS[0].level == $past(WRITEDATA[15:14]) - 2'h1)
    else $error("flash field wrong");
  a_levels_hold: assert property (!(WRITE && !WAITREQUEST && CE) |=>
    $stable(DEBUG_LEVELS) && $stable(PERIPH_LEVELS)) else $error("levels moved without a write");
endmodule : prio_bank_props
bind interrupt_priority_config_bank prio_bank_props u_props (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE),
  .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE),
  .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .DEBUG_LEVELS(DEBUG_LEVELS), .PERIPH_LEVELS(PERIPH_LEVELS));

// ===== testbench/core_model.sv
// Far-side model of the core: records which sources may wake it.
// Assumes the bank's level outputs and a low-power flag from the bench.
`timescale 1ns/10ps
module core_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic low_power,
  input wire logic [89:0] levels,
  output logic [29:0] wake_mask
);
  logic was_low;
  logic [29:0] next_wake_mask;
  // Snapshot on entry; later edits must not add wake sources while asleep
  always_comb begin
    next_wake_mask = wake_mask;
    if (low_power && !was_low) begin
      for (int i = 0; i < 30; i++) begin
        next_wake_mask[i] = levels[3 * i + 2];
      end
    end
  end
  // State registers only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wake_mask <= '0;
      was_low <= 1'b0;
    end else begin
      wake_mask <= next_wake_mask;
      was_low <= low_power;
    end
  end
endmodule : core_model

// ===== testbench/interrupt_priority_config_bank_bench.sv
// Self-checking bench for the priority bank over its Avalon-MM port.
// Assumes the bank, its bound checker and the core model compile alongside.
`timescale 1ns/10ps
`include "prio_regs.svh"
module interrupt_priority_config_bank_bench;
  logic clock;
  logic rst_n;
  logic ce;
  logic read;
  logic write;
  logic low_power;
  logic [7:0] address;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  prio_pkg::level_s [`DEBUG_SOURCES-1:0] dbg_lv;
  prio_pkg::level_s [`PERIPH_SOURCES-1:0] per_lv;
  logic [29:0] wake_mask;
  logic [31:0] q;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Field low bits, debug sources first, then peripherals in output order
  int pos[30] = '{4, 2, 0, 14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2, 14, 12, 10, 4, 2, 0, 14, 12, 10, 8, 4, 2, 0};
  logic [7:0] addr_tab[5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [15:0] mask_tab[5] = '{16'h003F, 16'hFFCF, 16'hFFFC, 16'hFC3F, 16'hFF3F};

  interrupt_priority_config_bank u_dut (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .ADDRESS(address), .READ(read),
    .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(byteenable), .READDATA(readdata),
    .WAITREQUEST(waitrequest), .DEBUG_LEVELS(dbg_lv), .PERIPH_LEVELS(per_lv));
  core_model u_core (.clock(clock), .rst_n(rst_n), .low_power(low_power), .levels({per_lv, dbg_lv}),
    .wake_mask(wake_mask));

  // Free-running 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // One access, held until waitrequest is seen low; read data lands in q
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
    int n;
    @(posedge clock);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= {16'h0, d};
    byteenable <= be;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    q = readdata;
    if (n >= 100) n_mismatch++;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  // Levels are looked at once the landing edge has settled
  task automatic cmp_levels(input logic [89:0] exp);
    #1;
    samples_checked++;
    if ({per_lv, dbg_lv} !== exp) begin
      n_mismatch++;
      $display("MISMATCH levels expected %h seen %h", exp, {per_lv, dbg_lv});
    end
  endtask : cmp_levels

  function automatic logic [2:0] lv(input int k, input logic [1:0] c);
    if (c == 2'h0) return 3'h0;
    return (k < 3) ? {1'b1, c} : {1'b1, c - 2'h1};
  endfunction : lv

  function automatic int bank_of(input int k);
    return (k < 3) ? 0 : (k < 10) ? 1 : (k < 17) ? 2 : (k < 23) ? 3 : 4;
  endfunction : bank_of

  task automatic t_reset_state;
    cmp_levels('0);
    for (int b = 0; b < 5; b++) begin
      bus(1'b0, addr_tab[b], 16'h0, 4'h0);
      cmp_word("reset word", 32'h0, q);
    end
  endtask : t_reset_state

  // Byte lanes, reserved bits and unmapped words
  task automatic t_masks;
    for (int b = 0; b < 5; b++) begin
      bus(1'b1, addr_tab[b], 16'hFFFF, 4'h1);
      bus(1'b0, addr_tab[b], 16'h0, 4'h0);
      cmp_word("low lane", {16'h0, mask_tab[b] & 16'h00FF}, q);
      bus(1'b1, addr_tab[b], 16'hFFFF, 4'h3);
      bus(1'b0, addr_tab[b], 16'h0, 4'h0);
      cmp_word("full word", {16'h0, mask_tab[b]}, q);
      bus(1'b1, addr_tab[b], 16'h0, 4'hF);
    end
    bus(1'b1, 8'h18, 16'hFFFF, 4'hF);
    bus(1'b0, 8'h18, 16'h0, 4'h0);
    cmp_word("unmapped high", 32'h0, q);
    bus(1'b0, 8'h00, 16'h0, 4'h0);
    cmp_word("unmapped low", 32'h0, q);
    cmp_levels('0);
  endtask : t_masks

  // Each field alone with one code, 1 to 3 in rotation from field to field, then cleared back to 00
  task automatic t_fields;
    logic [89:0] exp;
    logic [1:0] c;
    for (int k = 0; k < 30; k++) begin
      c = 2'(k % 3 + 1);
      bus(1'b1, addr_tab[bank_of(k)], {14'h0, c} << pos[k], 4'h3);
      exp = '0;
      exp[3 * k +: 3] = lv(k, c);
      cmp_levels(exp);
      bus(1'b1, addr_tab[bank_of(k)], 16'h0, 4'h3);
      cmp_levels('0);
    end
  endtask : t_fields

  // Only sources enabled before low power may wake the core
  task automatic t_wake;
    bus(1'b1, 8'h10, 16'h0010, 4'h3);
    @(posedge clock);
    low_power <= 1'b1;
    repeat (2) @(posedge clock);
    bus(1'b1, 8'h10, 16'h0014, 4'h3);
    #1;
    cmp_word("wake mask", 32'h0010_0000, {2'h0, wake_mask});
    low_power <= 1'b0;
    bus(1'b1, 8'h10, 16'h0, 4'h3);
  endtask : t_wake

  // Levels hold while the clock enable is low; a mid-run reset wins over it
  task automatic t_reset_again;
    logic [89:0] exp;
    exp = '0;
    exp[9 +: 3] = lv(3, 2'h1);
    bus(1'b1, 8'h08, 16'h4000, 4'h3);
    @(posedge clock);
    ce <= 1'b0;
    repeat (3) @(posedge clock);
    cmp_levels(exp);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    ce <= 1'b1;
    cmp_levels('0);
    bus(1'b0, 8'h08, 16'h0, 4'h0);
    cmp_word("word after reset", 32'h0, q);
  endtask : t_reset_again

  task automatic summarize;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    read = 1'b0;
    write = 1'b0;
    low_power = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'h0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset_state();
    t_masks();
    t_fields();
    t_wake();
    t_reset_again();
    summarize();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    summarize();
  end
endmodule : interrupt_priority_config_bank_bench
